// ==== src/usbav_regs.vh ====
// Constants for the USB and FIFO interrupt autovector block
`ifndef USBAV_REGS_VH
`define USBAV_REGS_VH

// ****************************************
// Source counts
// ****************************************
`define USBAV_USB_SRC_N      27
`define USBAV_FIFO_SRC_N     14

// ****************************************
// Code addresses of the USB interrupt entry
// ****************************************
`define USBAV_USB_ENTRY      16'h0043
`define USBAV_USB_PAGE_ADDR  16'h0044
`define USBAV_USB_VEC_ADDR   16'h0045

// ****************************************
// FIFO entry default and vector layout
// ****************************************
`define USBAV_FIFO_ENTRY     16'h0053
`define USBAV_FIFO_VEC_BASE  8'h80
`define USBAV_USB_VEC_BASE   8'h00
`define USBAV_VEC_SHIFT      2

// ****************************************
// USB source positions (priority minus one)
// ****************************************
`define USBAV_SRC_SETUP_DATA 0
`define USBAV_SRC_SOF        1
`define USBAV_SRC_SETUP_TOK  2
`define USBAV_SRC_SUSPEND    3
`define USBAV_SRC_BUS_RESET  4
`define USBAV_SRC_RSVD_A     5
`define USBAV_SRC_HS_ACK     6
`define USBAV_SRC_RSVD_B     7
`define USBAV_SRC_EP0_IN     8
`define USBAV_SRC_EP0_OUT    9
`define USBAV_SRC_EP1_IN     10
`define USBAV_SRC_EP1_OUT    11
`define USBAV_SRC_EP2        12
`define USBAV_SRC_IN_NAK     16
`define USBAV_SRC_EXTRA      17
`define USBAV_USB_RSVD_MASK  27'h00000A0

`endif

// ==== src/usbav_prio_enc.v ====
// Priority encoder that turns pending sources into a vector byte
`timescale 1ns/1ps
`default_nettype none

module usbav_prio_enc #(
    parameter       N     = 27,
    parameter       IW    = 5,
    parameter [7:0] BASE  = 8'h00,
    parameter       SHIFT = 2
) (
    // Pending sources, bit 0 is the highest priority
    input  wire [N-1:0] pend_i,
    // Result
    output reg          any_o,
    output reg  [7:0]   vec_o
);

    reg [IW-1:0] idx;
    integer      i;

    // Scan downward so the lowest set index is the last to win
    always @* begin
        idx   = {IW{1'b0}};
        any_o = 1'b0;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (pend_i[i]) begin
                idx   = i[IW-1:0];
                any_o = 1'b1;
            end
        end
        vec_o = BASE + ({{(8-IW){1'b0}}, idx} << SHIFT);
    end

endmodule
`default_nettype wire

// ==== src/usbav_top.v ====
// USB and FIFO interrupt gathering with autovector substitution
//
// Contract
// - Merge 27 USB sources into one line and 14 FIFO sources into another.
// - USB interrupt pushes PC and branches to code address 0x0043.
// - With USB autovector enabled, fetch at 0x0045 returns the USB vector byte.
// - FIFO interrupt gets same substitution with priority-ordered vectors for 14 sources.
// - USB vectors step by four: setup data 00, SOF 04, token 08, suspend 0C, reset 10.
// - Control handshake acknowledged is priority 7, vector 18.
// - Endpoint 0 IN 20, OUT 24; endpoint 1 IN 28, OUT 2C.
// - Endpoints 2, 4, 6, 8 buffer events use vectors 30 to 3C, priorities 13-16.
// - IN bulk NAK on any IN endpoint is priority 17, vector 40.
`timescale 1ns/1ps
`default_nettype none
`include "usbav_regs.vh"

module usbav_top #(
    parameter        USB_N      = `USBAV_USB_SRC_N,
    parameter        FIFO_N     = `USBAV_FIFO_SRC_N,
    parameter [15:0] FIFO_ENTRY = `USBAV_FIFO_ENTRY
) (
    // Clock and reset
    input  wire                clock_i,
    input  wire                rst_i,
    // Named USB events, one-cycle pulses
    input  wire                setup_data_available_i,
    input  wire                sof_i,
    input  wire                setup_token_received_i,
    input  wire                suspend_i,
    input  wire                bus_reset_i,
    input  wire                control_handshake_acked_i,
    input  wire                ep0_in_ready_i,
    input  wire                ep0_out_data_i,
    input  wire                ep1_in_ready_i,
    input  wire                ep1_out_data_i,
    input  wire [3:0]          ep_buffer_event_i,
    input  wire                in_bulk_nak_i,
    input  wire [USB_N-18:0]   usb_extra_event_i,
    // FIFO and programmable interface events
    input  wire [FIFO_N-1:0]   fifo_event_i,
    // Firmware side control
    input  wire [USB_N-1:0]    usb_enable_i,
    input  wire [USB_N-1:0]    usb_clear_i,
    input  wire [FIFO_N-1:0]   fifo_enable_i,
    input  wire [FIFO_N-1:0]   fifo_clear_i,
    input  wire                usb_autovector_enable_i,
    input  wire                fifo_autovector_enable_i,
    // Core interrupt entry
    input  wire                irq_take_i,
    // Core code fetch path
    input  wire                code_rd_i,
    input  wire [15:0]         code_addr_i,
    input  wire [7:0]          code_data_i,
    // Interrupt lines
    output reg                 usb_interrupt_line_o,
    output reg                 fifo_interrupt_line_o,
    // Entry request to the core
    output reg                 entry_req_o,
    output reg                 push_pc_o,
    output reg  [15:0]         entry_addr_o,
    // Vectors and fetched byte
    output reg  [7:0]          usb_vector_byte_o,
    output reg  [7:0]          fifo_vector_byte_o,
    output reg                 code_valid_o,
    output reg  [7:0]          code_data_o,
    // Pending state
    output reg  [USB_N-1:0]    usb_pending_o,
    output reg  [FIFO_N-1:0]   fifo_pending_o
);

    // ****************************************
    // Source assembly
    // ****************************************
    wire [USB_N-1:0] usb_event;
    wire [USB_N-1:0] usb_pend_d;
    wire [FIFO_N-1:0] fifo_pend_d;
    wire             usb_any;
    wire             fifo_any;
    wire [7:0]       usb_vec;
    wire [7:0]       fifo_vec;
    wire             usb_sub;
    wire             fifo_sub;

    // Positions 5 and 7 stay empty: their vectors 14 and 1C are reserved
    // Sources 18 to 27 continue the four-byte steps past vector 40
    assign usb_event = {usb_extra_event_i,
                        in_bulk_nak_i,
                        ep_buffer_event_i,
                        ep1_out_data_i,
                        ep1_in_ready_i,
                        ep0_out_data_i,
                        ep0_in_ready_i,
                        1'b0,
                        control_handshake_acked_i,
                        1'b0,
                        bus_reset_i,
                        suspend_i,
                        setup_token_received_i,
                        sof_i,
                        setup_data_available_i};

    // ****************************************
    // Sticky pending bits
    // ****************************************
    // A new event beats a clear in the same cycle
    // Reserved positions stay masked even if a wider event word is built
    assign usb_pend_d  = ((usb_pending_o & ~usb_clear_i) | usb_event)
                         & ~`USBAV_USB_RSVD_MASK;
    assign fifo_pend_d = (fifo_pending_o & ~fifo_clear_i) | fifo_event_i;

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            usb_pending_o  <= {USB_N{1'b0}};
            fifo_pending_o <= {FIFO_N{1'b0}};
        end else begin
            usb_pending_o  <= usb_pend_d;
            fifo_pending_o <= fifo_pend_d;
        end
    end

    // ****************************************
    // Priority encoding
    // ****************************************
    // Only enabled pending sources compete for the vector
    usbav_prio_enc #(
        .N     (USB_N),
        .IW    (5),
        .BASE  (`USBAV_USB_VEC_BASE),
        .SHIFT (`USBAV_VEC_SHIFT)
    ) u_usb_enc (
        .pend_i (usb_pending_o & usb_enable_i),
        .any_o  (usb_any),
        .vec_o  (usb_vec)
    );

    usbav_prio_enc #(
        .N     (FIFO_N),
        .IW    (4),
        .BASE  (`USBAV_FIFO_VEC_BASE),
        .SHIFT (`USBAV_VEC_SHIFT)
    ) u_fifo_enc (
        .pend_i (fifo_pending_o & fifo_enable_i),
        .any_o  (fifo_any),
        .vec_o  (fifo_vec)
    );

    // ****************************************
    // Registered lines and vectors
    // ****************************************
    // Registered so the core never sees a vector settle mid-fetch
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            usb_interrupt_line_o  <= 1'b0;
            fifo_interrupt_line_o <= 1'b0;
            usb_vector_byte_o     <= 8'h00;
            fifo_vector_byte_o    <= 8'h00;
        end else begin
            usb_interrupt_line_o  <= usb_any;
            fifo_interrupt_line_o <= fifo_any;
            usb_vector_byte_o     <= usb_vec;
            fifo_vector_byte_o    <= fifo_vec;
        end
    end

    // ****************************************
    // Interrupt entry
    // ****************************************
    // USB line wins when both are up; the core then handles FIFO next
    // A take with no line up is ignored and the address holds
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            entry_req_o  <= 1'b0;
            push_pc_o    <= 1'b0;
            entry_addr_o <= 16'h0000;
        end else begin
            entry_req_o <= 1'b0;
            push_pc_o   <= 1'b0;
            if (irq_take_i && usb_interrupt_line_o) begin
                entry_req_o  <= 1'b1;
                push_pc_o    <= 1'b1;
                entry_addr_o <= `USBAV_USB_ENTRY;
            end else if (irq_take_i && fifo_interrupt_line_o) begin
                entry_req_o  <= 1'b1;
                push_pc_o    <= 1'b1;
                entry_addr_o <= FIFO_ENTRY;
            end
        end
    end

    // ****************************************
    // Code fetch substitution
    // ****************************************
    // Page byte at entry+1 always passes through from memory
    // Any fetch of the vector address is replaced, not only one after
    // an entry: firmware must keep other code away from it
    // A source arriving between entry and fetch can still move the vector
    assign usb_sub  = usb_autovector_enable_i
                      && (code_addr_i == `USBAV_USB_VEC_ADDR);
    assign fifo_sub = fifo_autovector_enable_i
                      && (code_addr_i == FIFO_ENTRY + 16'h0002);

    // Answer lands one cycle after the request
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            code_valid_o <= 1'b0;
            code_data_o  <= 8'h00;
        end else begin
            code_valid_o <= code_rd_i;
            if (code_rd_i) begin
                if (usb_sub) begin
                    code_data_o <= usb_vector_byte_o;
                end else if (fifo_sub) begin
                    code_data_o <= fifo_vector_byte_o;
                end else begin
                    code_data_o <= code_data_i;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== test/usbav_top_properties.sv ====
// Checker for the USB and FIFO interrupt autovector block
`timescale 1ns/1ps
`default_nettype none
module usbav_chk #(
    parameter        USB_N      = 27,
    parameter [15:0] FIFO_ENTRY = 16'h0053
) (
    input wire logic             clock_i,
    input wire logic             rst_i,
    input wire logic [USB_N-1:0] usb_enable_i,
    input wire logic             usb_autovector_enable_i,
    input wire logic             fifo_autovector_enable_i,
    input wire logic             irq_take_i,
    input wire logic             code_rd_i,
    input wire logic [15:0]      code_addr_i,
    input wire logic [7:0]       code_data_i,
    input wire logic             usb_interrupt_line_o,
    input wire logic             fifo_interrupt_line_o,
    input wire logic             entry_req_o,
    input wire logic             push_pc_o,
    input wire logic [15:0]      entry_addr_o,
    input wire logic [7:0]       usb_vector_byte_o,
    input wire logic [7:0]       fifo_vector_byte_o,
    input wire logic             code_valid_o,
    input wire logic [7:0]       code_data_o,
    input wire logic [USB_N-1:0] usb_pending_o
);
    // Lowest pending index wins, four bytes per table entry
    function automatic logic [7:0] first_vec(input logic [USB_N-1:0] p);
        first_vec = 8'h00;
        for (int i = USB_N - 1; i >= 0; i--)
            if (p[i]) first_vec = 8'(i * 4);
    endfunction
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    chk_reserved_idle: assert property (!usb_pending_o[5] && !usb_pending_o[7])
        else $error("reserved source pending");
    chk_line_any: assert property (usb_interrupt_line_o == $past(|(usb_pending_o & usb_enable_i)))
        else $error("usb line wrong");
    chk_vec_prio: assert property (usb_vector_byte_o == first_vec($past(usb_pending_o & usb_enable_i)))
        else $error("usb vector wrong");
    chk_entry_usb: assert property (irq_take_i && usb_interrupt_line_o |=>
        entry_req_o && push_pc_o && entry_addr_o == 16'h0043) else $error("usb entry wrong");
    chk_entry_fifo: assert property (irq_take_i && !usb_interrupt_line_o && fifo_interrupt_line_o |=>
        entry_req_o && push_pc_o && entry_addr_o == FIFO_ENTRY) else $error("fifo entry wrong");
    chk_entry_cause: assert property (entry_req_o |-> $past(irq_take_i))
        else $error("entry without take");
    chk_av_usb: assert property (code_rd_i && code_addr_i == 16'h0045 && usb_autovector_enable_i |=>
        code_valid_o && code_data_o == $past(usb_vector_byte_o)) else $error("usb vector not fetched");
    chk_av_off: assert property (code_rd_i && code_addr_i == 16'h0045 && !usb_autovector_enable_i |=>
        code_data_o == $past(code_data_i)) else $error("byte replaced while off");
    chk_av_fifo: assert property (code_rd_i && code_addr_i == FIFO_ENTRY + 16'h0002 && fifo_autovector_enable_i
        |=> code_data_o == $past(fifo_vector_byte_o)) else $error("fifo vector not fetched");
    cover property (entry_req_o && entry_addr_o == FIFO_ENTRY);
    cover property (code_valid_o && usb_vector_byte_o == 8'h40);
    cover property (usb_interrupt_line_o && $rose(entry_req_o));
endmodule
bind usbav_top usbav_chk #(.USB_N(USB_N), .FIFO_ENTRY(FIFO_ENTRY)) u_usbav_chk (.*);
`default_nettype wire

// ==== test/usbav_core_model.sv ====
// Core model: takes an interrupt and fetches the three-byte entry jump
`timescale 1ns/1ps
`default_nettype none
module usbav_core_model #(
    parameter [7:0] PAGE = 8'h3C
) (
    input  wire logic        clock_i,
    input  wire logic        line_i,
    input  wire logic        entry_i,
    input  wire logic [15:0] entry_addr_i,
    input  wire logic        valid_i,
    input  wire logic [7:0]  data_i,
    input  wire logic        slow_i,
    output var  logic        take_o,
    output var  logic        rd_o,
    output var  logic [15:0] addr_o,
    output var  logic [7:0]  mem_o,
    output var  logic [15:0] target_o,
    output var  logic        done_o
);
    logic prev = 1'b0;
    int   left = 0;
    int   got = 0;
    // Page byte sits one after each entry; other bytes are filler
    function automatic logic [7:0] rom(input logic [15:0] a);
        return (a[3:0] == 4'h4) ? PAGE : a[7:0] ^ 8'hA5;
    endfunction
    initial {take_o, rd_o, addr_o, mem_o, target_o, done_o} = '0;
    always @(negedge clock_i) begin
        take_o <= line_i && !prev;
        prev <= line_i;
        done_o <= (got == 3);
        rd_o <= 1'b0;
        // Released data bus keeps toggling so a stale byte is never seen
        mem_o <= ~mem_o;
        if (entry_i) begin
            left <= 3;
        end else if (left > 0 && !(slow_i && rd_o)) begin
            rd_o <= 1'b1;
            addr_o <= entry_addr_i + 16'(3 - left);
            mem_o <= rom(entry_addr_i + 16'(3 - left));
            left <= left - 1;
        end
        if (valid_i) begin
            target_o <= {target_o[7:0], data_i};
            got <= got + 1;
        end else if (got == 3) begin
            got <= 0;
        end
    end
endmodule
`default_nettype wire

// ==== test/test_usbav_top.sv ====
// Testbench for the USB and FIFO interrupt autovector block
`timescale 1ns/1ps
`default_nettype none
module test_usbav_top;
    localparam logic [7:0] PAGE = 8'h3C;
    logic        clock_i, rst_i, usb_av, fifo_av, slow, take, rd, ul, fl, ereq, ppc, cv, done;
    logic [26:0] ev = '0, en = '1, clr = '0, upend;
    logic [13:0] fev = '0, fen = '1, fclr = '0, fpend;
    logic [15:0] fa, ea, target;
    logic [7:0]  mem, uvec, fvec, cd;
    int          failures = 0, checks_done = 0;
    int          srcs[15] = '{0, 1, 2, 3, 4, 6, 8, 9, 10, 11, 12, 13, 14, 15, 16};
    usbav_top u_usbav_top (
        .clock_i(clock_i), .rst_i(rst_i), .setup_data_available_i(ev[0]), .sof_i(ev[1]),
        .setup_token_received_i(ev[2]), .suspend_i(ev[3]), .bus_reset_i(ev[4]),
        .control_handshake_acked_i(ev[6]), .ep0_in_ready_i(ev[8]), .ep0_out_data_i(ev[9]),
        .ep1_in_ready_i(ev[10]), .ep1_out_data_i(ev[11]), .ep_buffer_event_i(ev[15:12]),
        .in_bulk_nak_i(ev[16]), .usb_extra_event_i(ev[26:17]), .fifo_event_i(fev),
        .usb_enable_i(en), .usb_clear_i(clr), .fifo_enable_i(fen), .fifo_clear_i(fclr),
        .usb_autovector_enable_i(usb_av), .fifo_autovector_enable_i(fifo_av), .irq_take_i(take),
        .code_rd_i(rd), .code_addr_i(fa), .code_data_i(mem), .usb_interrupt_line_o(ul),
        .fifo_interrupt_line_o(fl), .entry_req_o(ereq), .push_pc_o(ppc), .entry_addr_o(ea),
        .usb_vector_byte_o(uvec), .fifo_vector_byte_o(fvec), .code_valid_o(cv),
        .code_data_o(cd), .usb_pending_o(upend), .fifo_pending_o(fpend));
    usbav_core_model #(.PAGE(PAGE)) u_usbav_core_model (
        .clock_i(clock_i), .line_i(ul | fl), .entry_i(ereq), .entry_addr_i(ea), .valid_i(cv),
        .data_i(cd), .slow_i(slow), .take_o(take), .rd_o(rd), .addr_o(fa), .mem_o(mem),
        .target_o(target), .done_o(done));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Bounded wait for the core's jump; a hang closes the run
    task automatic take_jump(input logic [7:0] vec);
        for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge clock_i);
        if (done !== 1'b1) begin
            failures++;
            $display("ERROR jump expected done seen none");
            results();
        end
        check("jump target", {PAGE, vec}, target);
    endtask
    task automatic clear_all();
        @(negedge clock_i);
        clr = '1;
        fclr = '1;
        @(negedge clock_i);
        clr = '0;
        fclr = '0;
        repeat (2) @(negedge clock_i);
        check("lines", 16'h0000, {14'h0000, ul, fl});
    endtask
    task automatic pulse(input logic [26:0] u, input logic [13:0] f);
        @(negedge clock_i);
        ev = u;
        fev = f;
        @(negedge clock_i);
        ev = '0;
        fev = '0;
    endtask
    // Every named source alone, fetch alternating fast and slow
    task automatic t_sources();
        foreach (srcs[k]) begin
            slow = k[0];
            pulse(27'(1) << srcs[k], 14'h0000);
            take_jump(8'(srcs[k] * 4));
            check("entry", 16'h0043, ea);
            clear_all();
        end
    endtask
    task automatic t_prio();
        pulse(27'h0010044, 14'h0000);
        take_jump(8'h08);
        en[2] = 1'b0;
        repeat (3) @(negedge clock_i);
        check("masked vector", 16'h0018, {8'h00, uvec});
        en = '1;
        clear_all();
    endtask
    task automatic t_noav();
        usb_av = 1'b0;
        pulse(27'h0000002, 14'h0000);
        take_jump(8'h45 ^ 8'hA5);
        usb_av = 1'b1;
        clear_all();
        fifo_av = 1'b0;
        pulse(27'h0000000, 14'h0001);
        take_jump(8'h55 ^ 8'hA5);
        fifo_av = 1'b1;
        clear_all();
    endtask
    task automatic t_fifo();
        fen = 14'h3FFD;
        pulse(27'h0000000, 14'h000A);
        take_jump(8'h8C);
        check("fifo entry", 16'h0053, ea);
        check("fifo pending", 16'h000A, {2'b00, fpend});
        fen = '1;
        clear_all();
    endtask
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        rst_i = 1'b1;
        usb_av = 1'b1;
        fifo_av = 1'b1;
        slow = 1'b0;
        repeat (2) @(negedge clock_i);
        rst_i = 1'b0;
        check("pending", 16'h0000, upend[15:0]);
        t_sources();
        t_prio();
        t_noav();
        t_fifo();
        results();
    end
endmodule
`default_nettype wire
